// [include/aoc_pkg.sv]
// constants for the auxiliary output control block
package aoc_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] PULSE_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] CARRIER_OFS = 4'h8;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'hc;
  // control register fields
  localparam int unsigned SW_MODE_LSB = 0;
  localparam int unsigned KNOB_AS_INTERCEPT_BIT = 2;
  localparam int unsigned KNOB_ACTIVE_HIGH_BIT = 3;
  localparam int unsigned STATUS_INTERCEPT_HIGH_BIT = 4;
  localparam int unsigned LEARN_BIT = 5;
  localparam int unsigned ENVELOPE_PATH_BIT = 6;
  localparam int unsigned ENVELOPE_INVERT_BIT = 7;
  localparam int unsigned MUTE_ACTIVE_HIGH_BIT = 8;
  localparam int unsigned RX_POWER_BIT = 9;
  localparam int unsigned CTRL_W = 10;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h008;
  // status register fields
  localparam int unsigned ST_SW_CLOSED_BIT = 0;
  localparam int unsigned ST_INTERCEPTED_BIT = 1;
  localparam int unsigned ST_IR_RX_BIT = 2;
  localparam int unsigned ST_KNOB_BIT = 3;
  localparam int unsigned ST_PULSING_BIT = 4;
  // pulse width in milliseconds
  localparam int unsigned PULSE_W = 13;
  localparam logic [PULSE_W-1:0] PULSE_MIN_MS = 13'h0001;
  localparam logic [PULSE_W-1:0] PULSE_MAX_MS = 13'h1388;
  localparam logic [PULSE_W-1:0] PULSE_RESET_MS = 13'h012c;
  // carrier half period in clock cycles
  localparam int unsigned CARRIER_W = 16;
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned CARRIER_RESET_HZ = 38000;
  localparam logic [CARRIER_W-1:0] CARRIER_RESET_HALF =
    CARRIER_W'(64'd1_000_000_000_000 / (2 * CARRIER_RESET_HZ * CLK_PERIOD_PS));
  localparam int unsigned MS_PS = 1_000_000_000;
  localparam int unsigned MS_CYCLES = MS_PS / CLK_PERIOD_PS;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    SW_PULSE,
    SW_PULSE_INV,
    SW_LEVEL,
    SW_LEVEL_INV
  } aoc_sw_mode_t;
  typedef enum {
    SW_IDLE,
    SW_ACTIVE
  } aoc_sw_state_t;
endpackage

// [rtl/aoc_top.sv]
// auxiliary switch, status, remote control and mute line logic
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`default_nettype none
module aoc_top
  import aoc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = aoc_pkg::MS_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [aoc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [aoc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic knob_intercept_in,
  input wire logic nav_speaking,
  input wire logic rc_envelope,
  output logic source_switch_out,
  output logic panel_intercept_en,
  input wire logic panel_status_line_i,
  output logic panel_status_line_o,
  output logic panel_status_line_oe,
  output logic ir_emitter_out,
  output logic envelope_out,
  output logic mute_or_rx_power,
  output logic ir_rx_sample
);
  import aoc_pkg::*;

  logic [CTRL_W-1:0] ctrl_reg;
  logic [PULSE_W-1:0] pulse_ms_reg;
  logic [CARRIER_W-1:0] carrier_half_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_go;
  logic rd_go;

  // ---- register bus
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign rd_go = s_axi_arvalid && !rvalid_reg;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  logic [31:0] wmask;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{s_axi_wstrb[i]}};
    end
  end

  logic [31:0] ctrl_word;
  logic [31:0] pulse_word;
  logic [31:0] carrier_word;
  logic [PULSE_W-1:0] pulse_wr;
  assign ctrl_word = (32'(ctrl_reg) & ~wmask) | (s_axi_wdata & wmask);
  assign pulse_word = (32'(pulse_ms_reg) & ~wmask) | (s_axi_wdata & wmask);
  assign carrier_word = (32'(carrier_half_reg) & ~wmask) | (s_axi_wdata & wmask);
  // out of range widths clamp so the pulse stays inside 1..5000 ms
  assign pulse_wr = (pulse_word < 32'(PULSE_MIN_MS)) ? PULSE_MIN_MS :
                    (pulse_word > 32'(PULSE_MAX_MS)) ? PULSE_MAX_MS : pulse_word[PULSE_W-1:0];

  // receiver power bit clears on every reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
      pulse_ms_reg <= PULSE_RESET_MS;
      carrier_half_reg <= CARRIER_RESET_HALF;
    end else if (wr_go) begin
      case (s_axi_awaddr)
        CTRL_OFS: ctrl_reg <= ctrl_word[CTRL_W-1:0];
        PULSE_OFS: pulse_ms_reg <= pulse_wr;
        CARRIER_OFS: carrier_half_reg <= (carrier_word[CARRIER_W-1:0] == '0) ?
                                         CARRIER_W'(1) : carrier_word[CARRIER_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (s_axi_awaddr == CTRL_OFS || s_axi_awaddr == PULSE_OFS ||
                    s_axi_awaddr == CARRIER_OFS) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ---- input synchronisers
  logic [1:0] knob_sync;
  logic [1:0] status_sync;
  logic knob_prev_reg;
  logic knob_active;
  logic knob_press;
  logic knob_as_intercept;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      knob_sync <= 2'b00;
      status_sync <= 2'b00;
      knob_prev_reg <= 1'b0;
    end else begin
      knob_sync <= {knob_sync[0], knob_intercept_in};
      status_sync <= {status_sync[0], panel_status_line_i};
      knob_prev_reg <= knob_active;
    end
  end

  assign knob_as_intercept = ctrl_reg[KNOB_AS_INTERCEPT_BIT];
  assign knob_active = knob_sync[1] == ctrl_reg[KNOB_ACTIVE_HIGH_BIT];
  // no debounce here: a bouncing knob can give extra presses
  assign knob_press = knob_active && !knob_prev_reg && !knob_as_intercept;

  // ---- millisecond tick
  logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt_reg;
  logic ms_tick;
  assign ms_tick = tick_cnt_reg == ($bits(tick_cnt_reg))'(TICK_CYCLES - 1);

  // ---- source switch
  aoc_sw_mode_t sw_mode;
  aoc_sw_state_t sw_state_reg;
  logic [PULSE_W-1:0] ms_cnt_reg;
  logic level_reg;
  logic sw_closed;
  logic sw_inverted;
  logic sw_is_level;
  assign sw_mode = aoc_sw_mode_t'(ctrl_reg[SW_MODE_LSB +: 2]);
  assign sw_inverted = sw_mode == SW_PULSE_INV || sw_mode == SW_LEVEL_INV;
  assign sw_is_level = sw_mode == SW_LEVEL || sw_mode == SW_LEVEL_INV;

  // tick restarts with each pulse so the first millisecond is whole
  always_ff @(posedge aclk) begin
    if (!aresetn || sw_state_reg == SW_IDLE || ms_tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_state_reg <= SW_IDLE;
      ms_cnt_reg <= '0;
    end else begin
      case (sw_state_reg)
        SW_IDLE: begin
          if (knob_press && !sw_is_level) begin
            sw_state_reg <= SW_ACTIVE;
            ms_cnt_reg <= '0;
          end
        end
        SW_ACTIVE: begin
          if (ms_tick) begin
            if (ms_cnt_reg + 1'b1 >= pulse_ms_reg) begin
              sw_state_reg <= SW_IDLE;
            end
            ms_cnt_reg <= ms_cnt_reg + 1'b1;
          end
        end
        default: sw_state_reg <= SW_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_reg <= 1'b0;
    end else if (knob_press && sw_is_level) begin
      level_reg <= !level_reg;
    end
  end

  // active state is closed (sinking) unless inverted
  assign sw_closed = (sw_is_level ? level_reg : sw_state_reg == SW_ACTIVE) ^ sw_inverted;

  // ---- carrier
  logic [CARRIER_W-1:0] carrier_cnt_reg;
  logic carrier_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carrier_cnt_reg <= '0;
      carrier_reg <= 1'b0;
    end else if (carrier_cnt_reg + 1'b1 >= carrier_half_reg) begin
      carrier_cnt_reg <= '0;
      carrier_reg <= !carrier_reg;
    end else begin
      carrier_cnt_reg <= carrier_cnt_reg + 1'b1;
    end
  end

  // ---- registered pin drivers
  logic intercepted;
  logic learning;
  logic env_path;
  assign intercepted = knob_as_intercept && knob_active;
  assign learning = ctrl_reg[LEARN_BIT];
  assign env_path = ctrl_reg[ENVELOPE_PATH_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      source_switch_out <= 1'b0;
      panel_intercept_en <= 1'b0;
      panel_status_line_o <= 1'b0;
      panel_status_line_oe <= 1'b0;
      ir_emitter_out <= 1'b0;
      envelope_out <= 1'b0;
      mute_or_rx_power <= 1'b0;
      ir_rx_sample <= 1'b0;
    end else begin
      source_switch_out <= sw_closed;
      panel_intercept_en <= intercepted;
      panel_status_line_o <= intercepted ~^ ctrl_reg[STATUS_INTERCEPT_HIGH_BIT];
      panel_status_line_oe <= !learning;
      ir_rx_sample <= learning && status_sync[1];
      ir_emitter_out <= !env_path && rc_envelope && carrier_reg;
      envelope_out <= (env_path && rc_envelope) ^ ctrl_reg[ENVELOPE_INVERT_BIT];
      mute_or_rx_power <= ctrl_reg[RX_POWER_BIT] ||
                          (nav_speaking ~^ ctrl_reg[MUTE_ACTIVE_HIGH_BIT]);
    end
  end

  // ---- read path
  logic [31:0] status_word;
  assign status_word = {27'h0, sw_state_reg == SW_ACTIVE, knob_sync[1], ir_rx_sample,
                        intercepted, sw_closed};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      case (s_axi_araddr)
        CTRL_OFS: rdata_reg <= 32'(ctrl_reg);
        PULSE_OFS: rdata_reg <= 32'(pulse_ms_reg);
        CARRIER_OFS: rdata_reg <= 32'(carrier_half_reg);
        STATUS_OFS: rdata_reg <= status_word;
        default: begin
          rdata_reg <= 32'h0;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ---- assertions
  a_pulse_range: assert property (@(posedge aclk) disable iff (!aresetn)
    pulse_ms_reg >= PULSE_MIN_MS && pulse_ms_reg <= PULSE_MAX_MS)
    else $error("pulse width out of range");
  a_reset_defaults: assert property (@(posedge aclk)
    $rose(aresetn) |-> sw_mode == SW_PULSE && pulse_ms_reg == PULSE_RESET_MS)
    else $error("switch defaults wrong after reset");
  a_rx_power_off: assert property (@(posedge aclk)
    $rose(aresetn) |-> !ctrl_reg[RX_POWER_BIT])
    else $error("receiver power kept over reset");
  a_pulse_start: assert property (@(posedge aclk) disable iff (!aresetn)
    sw_state_reg == SW_IDLE && knob_press && !sw_is_level |=> sw_state_reg == SW_ACTIVE)
    else $error("knob press gave no pulse");
  a_level_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
    knob_press && sw_is_level |=> level_reg != $past(level_reg))
    else $error("knob press did not toggle level");
  a_pulse_end: assert property (@(posedge aclk) disable iff (!aresetn)
    sw_state_reg == SW_ACTIVE && ms_tick && ms_cnt_reg + 1'b1 >= pulse_ms_reg |=> sw_state_reg == SW_IDLE)
    else $error("pulse did not end at count");
  a_switch_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    sw_state_reg == SW_IDLE && !sw_is_level |=> source_switch_out == $past(sw_inverted))
    else $error("switch idle level wrong");
  a_one_path: assert property (@(posedge aclk) disable iff (!aresetn)
    ir_emitter_out |-> $past(!env_path))
    else $error("emitter active on envelope path");
  a_learn_input: assert property (@(posedge aclk) disable iff (!aresetn)
    learning |=> !panel_status_line_oe)
    else $error("status line driven while learning");
  a_rx_power_high: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_reg[RX_POWER_BIT] |=> mute_or_rx_power)
    else $error("receiver power not applied");
  a_status_level: assert property (@(posedge aclk) disable iff (!aresetn)
    intercepted && !learning |=> panel_status_line_o == $past(ctrl_reg[STATUS_INTERCEPT_HIGH_BIT]))
    else $error("status level wrong");
  a_intercept_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    sw_state_reg == SW_IDLE && knob_as_intercept |=> sw_state_reg == SW_IDLE)
    else $error("knob pulsed in intercept mode");
  a_pulse_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    sw_state_reg == SW_ACTIVE && !ms_tick |=> sw_state_reg == SW_ACTIVE)
    else $error("pulse ended off a tick");
  a_level_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    sw_is_level |=> source_switch_out == $past(level_reg ^ sw_inverted))
    else $error("level output wrong");
  a_emitter_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !rc_envelope |=> !ir_emitter_out)
    else $error("emitter sinks without envelope");
  a_envelope_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    !env_path |=> envelope_out == $past(ctrl_reg[ENVELOPE_INVERT_BIT]))
    else $error("envelope output not idle");
  a_mute_level: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_reg[RX_POWER_BIT] |=> mute_or_rx_power == $past(nav_speaking ~^ ctrl_reg[MUTE_ACTIVE_HIGH_BIT]))
    else $error("mute level wrong");
  a_learn_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    !learning |=> !ir_rx_sample)
    else $error("receiver sampled outside learning");
endmodule // aoc_top
`default_nettype wire

// [testbench/aoc_far_side.sv]
// far side model: serial source switcher, head unit emitter watch, ir receiver
`default_nettype none
module aoc_far_side (
  input wire logic aclk,
  input wire logic sw_closed,
  input wire logic emit_on,
  input wire logic rx_light,
  output logic rx_out,
  output int pulses,
  output int sw_width,
  output int emit_width
);
  timeunit 1ns;
  timeprecision 1ps;
  int sw_run = 0;
  int emit_run = 0;
  int pulse_cnt = 0;
  int sw_last = 0;
  int emit_last = 0;
  // receiver output is low while light arrives, high otherwise
  assign rx_out = !rx_light;
  assign pulses = pulse_cnt;
  assign sw_width = sw_last;
  assign emit_width = emit_last;
  // serial switcher advances one source at the end of each closed pulse
  always @(posedge aclk) begin
    if (sw_closed) begin
      sw_run++;
    end else if (sw_run != 0) begin
      pulse_cnt++;
      sw_last = sw_run;
      sw_run = 0;
    end
  end
  always @(posedge aclk) begin
    if (emit_on) begin
      emit_run++;
    end else if (emit_run != 0) begin
      emit_last = emit_run;
      emit_run = 0;
    end
  end
endmodule // aoc_far_side
`default_nettype wire

// [testbench/aux_output_control_tb.sv]
// self-checking bench for the auxiliary output control block
`default_nettype none
module aux_output_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import aoc_pkg::*;
  // io = {envelope in, nav speaking, envelope out, mute, status out}
  typedef struct packed {logic [9:0] ctrl; logic [4:0] io;} aoc_row_t;
  aoc_row_t rows [5] = '{'{10'h148, 5'h1f}, '{10'h1c8, 5'h11}, '{10'h0d8, 5'h06},
                         '{10'h208, 5'h1b}, '{10'h008, 5'h19}};
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic knob = 1'h0, nav = 1'h0, env = 1'h0, rx_light = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, sw_out, icpt, st_i, st_o, st_oe;
  logic ir_out, env_out, mute, rx_smp, rx_out;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int pulses, sw_width, emit_width, p0;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  // the status pin carries the receiver only while the block lets go of it
  assign st_i = st_oe ? st_o : rx_out;
  aoc_top #(.TICK_CYCLES(4)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .knob_intercept_in(knob), .nav_speaking(nav), .rc_envelope(env), .source_switch_out(sw_out),
    .panel_intercept_en(icpt), .panel_status_line_i(st_i), .panel_status_line_o(st_o),
    .panel_status_line_oe(st_oe), .ir_emitter_out(ir_out), .envelope_out(env_out),
    .mute_or_rx_power(mute), .ir_rx_sample(rx_smp));
  aoc_far_side far (.aclk(aclk), .sw_closed(sw_out), .emit_on(ir_out), .rx_light(rx_light),
    .rx_out(rx_out), .pulses(pulses), .sw_width(sw_width), .emit_width(emit_width));
  initial begin
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do @(posedge aclk); while (!(awready && wready));
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'h0;
    chk(32'(bresp), 32'(er));
    tick(1);
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'h0;
    chk(rdata, ed);
    chk(32'(rresp), 32'(er));
    tick(1);
  endtask
  // no debounce in the block, so a press is a clean high then low
  task automatic press();
    knob <= 1'h1;
    tick(6);
    knob <= 1'h0;
    tick(6);
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    tick(20);
    aresetn <= 1'h1;
    tick(1);
    chk(sw_out, 1'h0);
    axi_rd(CTRL_OFS, 32'(CTRL_RESET), RESP_OKAY);
    axi_rd(PULSE_OFS, 32'h12c, RESP_OKAY);
    axi_rd(CARRIER_OFS, 32'(CARRIER_RESET_HALF), RESP_OKAY);
    done("reset");
    foreach (rows[i]) begin
      axi_wr(CTRL_OFS, 32'(rows[i].ctrl), RESP_OKAY);
      env <= rows[i].io[4];
      nav <= rows[i].io[3];
      tick(3);
      chk(env_out, rows[i].io[2]);
      chk(mute, rows[i].io[1]);
      chk(st_o, rows[i].io[0]);
      if (rows[i].ctrl[6]) chk(ir_out, 1'h0);
    end
    done("table");
    axi_wr(PULSE_OFS, 32'h0, RESP_OKAY);
    axi_rd(PULSE_OFS, 32'h1, RESP_OKAY);
    axi_wr(PULSE_OFS, 32'h1fff, RESP_OKAY);
    axi_rd(PULSE_OFS, 32'h1388, RESP_OKAY);
    axi_wr(CARRIER_OFS, 32'h0, RESP_OKAY);
    axi_rd(CARRIER_OFS, 32'h1, RESP_OKAY);
    axi_wr(STATUS_OFS, 32'h1f, RESP_SLVERR);
    done("limits");
    axi_wr(PULSE_OFS, 32'h5, RESP_OKAY);
    tick(4);
    p0 = pulses;
    press();
    press();
    tick(20);
    chk(pulses, p0 + 1);
    chk(sw_width, 32'h14);
    press();
    tick(30);
    chk(pulses, p0 + 2);
    axi_wr(CTRL_OFS, 32'h009, RESP_OKAY);
    tick(3);
    chk(sw_out, 1'h1);
    axi_wr(CTRL_OFS, 32'h00a, RESP_OKAY);
    tick(3);
    chk(sw_out, 1'h0);
    press();
    chk(sw_out, 1'h1);
    axi_wr(CTRL_OFS, 32'h00b, RESP_OKAY);
    tick(3);
    chk(sw_out, 1'h0);
    press();
    chk(sw_out, 1'h1);
    done("switch");
    axi_wr(CTRL_OFS, 32'h008, RESP_OKAY);
    axi_wr(CARRIER_OFS, 32'h5, RESP_OKAY);
    env <= 1'h1;
    tick(40);
    chk(emit_width, 32'h5);
    env <= 1'h0;
    tick(15);
    chk(ir_out, 1'h0);
    done("carrier");
    axi_wr(CTRL_OFS, 32'h01c, RESP_OKAY);
    knob <= 1'h1;
    tick(6);
    chk(icpt, 1'h1);
    chk(st_o, 1'h1);
    chk(sw_out, 1'h0);
    axi_rd(STATUS_OFS, 32'ha, RESP_OKAY);
    knob <= 1'h0;
    tick(6);
    chk(icpt, 1'h0);
    done("intercept");
    axi_wr(CTRL_OFS, 32'h028, RESP_OKAY);
    tick(5);
    chk(st_oe, 1'h0);
    chk(rx_smp, 1'h1);
    rx_light <= 1'h1;
    tick(5);
    chk(rx_smp, 1'h0);
    done("learning");
    // active low knob: pin idles high, a press pulls it low
    knob <= 1'h1;
    tick(30);
    p0 = pulses;
    axi_wr(CTRL_OFS, 32'h000, RESP_OKAY);
    knob <= 1'h0;
    tick(6);
    chk(sw_out, 1'h1);
    knob <= 1'h1;
    tick(30);
    chk(pulses, p0 + 1);
    done("active low knob");
    axi_wr(CTRL_OFS, 32'h208, RESP_OKAY);
    tick(2);
    chk(mute, 1'h1);
    aresetn <= 1'h0;
    tick(2);
    aresetn <= 1'h1;
    tick(1);
    axi_rd(CTRL_OFS, 32'(CTRL_RESET), RESP_OKAY);
    done("power cycle");
    report_and_stop();
  end
endmodule // aux_output_control_tb
`default_nettype wire
